/* core/vpi_regs.vh */
`ifndef VPI_REGS_VH
`define VPI_REGS_VH
// ==========================================================
// Chip addresses
`define VPI_ADDR_FRONT        7'h47
`define VPI_ADDR_BACK         7'h45
// ==========================================================
// Subaddresses
`define VPI_SUB_BLACK_LINE    8'h12
`define VPI_SUB_PIN_DRIVER    8'h1F
`define VPI_SUB_SYNC_GEN      8'h20
`define VPI_SUB_PRIO_OVR      8'h23
`define VPI_SUB_PRIO_ID       8'h24
`define VPI_SUB_CP_STATUS     8'h35
`define VPI_SUB_CP_RD_ADDR    8'h36
`define VPI_SUB_CP_WR_ADDR    8'h37
`define VPI_SUB_CP_DATA       8'h38
// ==========================================================
// Reset values and field positions
`define VPI_RST_ZERO          16'h0000
`define VPI_BLACK_RESTART     7'h7F
`define VPI_STR_HIZ           3'h7
`define VPI_ST_WREQ           0
`define VPI_ST_RREQ           1
`define VPI_ST_BUSY           2
// ==========================================================
// Timing
`define VPI_INT_RESET_NS      4000
`define VPI_CLK_NS            4
`define VPI_INT_RESET_CYC     ((`VPI_INT_RESET_NS + `VPI_CLK_NS - 1) / `VPI_CLK_NS)
`define VPI_INIT_CYC          64
`endif

/* core/vpi_port.v */
`include "vpi_regs.vh"
// Overview of operation
// - A single slave port that answers only the front chip address; the back address is not served.
// - The port never holds SCL low; the master still waits for SCL release.
// - One subaddress byte follows the chip address and picks a register.
// - Front answers 1000111; back address 1000101 gets no answer; eighth bit is read/write.
// - Registers are 8 or 16 bits; 16-bit ones move as two bytes.
// - Unimplemented upper bits ignored on write, read back as zero.
// - Hardware reset clears every control register to zero.
// - After reset an init phase of INIT_CYC cycles runs; it loads no defaults, registers stay zero.
// - Vertically latched registers apply at vsync, horizontal ones at hsync.
// - Coprocessor status: bit0 write request, bit1 read request, bit2 busy.
// - Read-address register holds 9 bits; next three reserved, written zero.
// - Write-address register holds 9 bits; next three reserved, written zero.
// - Data window read bumps read address, write bumps write address.
// - One 16-bit word per transaction on the data window.
// - Black line result: lower count, zero, upper count, black flag; restart 127.
// - 3-bit pin strength, 7 high impedance; a bit chooses push-pull or tristate.
// - A bit chooses whether interlace output syncs to main display sync.
// - Sync generator bit 7 gives interlace polarity; lower bits reserved.
// - Each set overwrite mask bit overwrites that priority level.
// - Priority control: 3-bit ID, 2-bit pad strength, bit 6 request source.
// - Priority interface disabled puts priority data pins in high impedance.
// - Internal reset lasts 4 us then init; no bus answers meanwhile.
module vpi_port #(
  parameter INT_RESET_CYC = `VPI_INT_RESET_CYC,
  parameter INIT_CYC      = `VPI_INIT_CYC
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        scl_in,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_oe,
  input  wire        vsync,
  input  wire        hsync,
  input  wire        black_meas_done,
  input  wire [6:0]  lower_black_count,
  input  wire [6:0]  upper_black_count,
  input  wire        black_picture_flag,
  output reg         black_restart,
  output reg         cp_wr_req,
  output reg  [8:0]  cp_wr_addr,
  output reg  [11:0] cp_wr_data,
  output reg         cp_rd_req,
  output reg  [8:0]  cp_rd_addr,
  input  wire [11:0] cp_rd_data,
  input  wire        cp_ack,
  input  wire        interlace_raw,
  output reg         interlace_signal,
  output reg         interlace_oe,
  output reg  [2:0]  output_strength,
  output reg  [7:0]  priority_overwrite_mask,
  output reg  [2:0]  priority_level_id,
  output reg  [1:0]  priority_pad_strength,
  output reg         priority_request_source,
  output reg         priority_data_oe,
  output reg         init_busy
);
  // ========================================================
  // Pin synchronisers (first stage read by second only)
  reg [1:0] scl_s_q, sda_s_q, vs_s_q, hs_s_q;
  reg       scl_q, sda_q, vs_q, hs_q;
  always @(posedge sys_clk) begin
    scl_s_q <= {scl_s_q[0], scl_in};
    sda_s_q <= {sda_s_q[0], sda_in};
    vs_s_q  <= {vs_s_q[0], vsync};
    hs_s_q  <= {hs_s_q[0], hsync};
    scl_q   <= scl_s_q[1];
    sda_q   <= sda_s_q[1];
    vs_q    <= vs_s_q[1];
    hs_q    <= hs_s_q[1];
  end
  wire scl_rise = scl_s_q[1] & ~scl_q;
  wire scl_fall = ~scl_s_q[1] & scl_q;
  wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
  wire vs_edge  = vs_s_q[1] & ~vs_q;
  wire hs_edge  = hs_s_q[1] & ~hs_q;

  // ========================================================
  // Internal reset then init: bus is deaf until both end
  localparam R_HOLD = 3'b001, R_INIT = 3'b010, R_RUN = 3'b100;
  reg [2:0]  rst_st_q;
  reg [15:0] rst_cnt_q;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rst_st_q  <= R_HOLD;
      rst_cnt_q <= 16'h0000;
    end else begin
      case (rst_st_q)
        R_HOLD: if (rst_cnt_q == INT_RESET_CYC - 1) begin
          rst_st_q  <= R_INIT;
          rst_cnt_q <= 16'h0000;
        end else rst_cnt_q <= rst_cnt_q + 16'h0001;
        R_INIT: if (rst_cnt_q == INIT_CYC - 1) rst_st_q <= R_RUN;
          else rst_cnt_q <= rst_cnt_q + 16'h0001;
        R_RUN: rst_st_q <= R_RUN;
        default: rst_st_q <= R_HOLD;
      endcase
    end
  end
  wire ready = rst_st_q[2];

  // ========================================================
  // Register file
  reg [15:0] pin_ctl_q, pin_act_q;
  reg [7:0]  sync_ctl_q, prio_ovr_q, prio_ctl_q;
  reg [7:0]  ovr_sh_q, pid_sh_q;
  reg [8:0]  rd_addr_q, wr_addr_q;
  reg [15:0] black_q;
  reg        wreq_q, rreq_q;
  reg        sync_int_q;

  // ========================================================
  // Serial slave engine
  localparam S_IDLE = 6'b000001, S_ADDR = 6'b000010, S_SUB = 6'b000100;
  localparam S_WDAT = 6'b001000, S_RDAT = 6'b010000, S_ACK = 6'b100000;
  reg [5:0]  st_q;
  reg [7:0]  sh_q, sub_q;
  reg [3:0]  bit_q;
  reg        rw_q, byte_n_q, is_addr_q, is_sub_q, mack_q;
  reg [7:0]  hi_q;

  function [15:0] rd_mux;
    input [7:0] sa;
    begin
      case (sa)
        `VPI_SUB_BLACK_LINE: rd_mux = black_q;
        `VPI_SUB_PIN_DRIVER: rd_mux = {10'h000, pin_ctl_q[5:4], 1'b0, pin_ctl_q[2:0]};
        `VPI_SUB_SYNC_GEN:   rd_mux = {8'h00, sync_ctl_q[7], 7'h00};
        `VPI_SUB_PRIO_OVR:   rd_mux = {8'h00, prio_ovr_q};
        `VPI_SUB_PRIO_ID:    rd_mux = {8'h00, prio_ctl_q[7:6], 1'b0, prio_ctl_q[4:0]};
        `VPI_SUB_CP_STATUS:  rd_mux = {13'h0000, ~ready | wreq_q | rreq_q, rreq_q, wreq_q};
        `VPI_SUB_CP_DATA:    rd_mux = {4'h0, cp_rd_data};
        default:             rd_mux = 16'h0000;
      endcase
    end
  endfunction

  function is_wide;
    input [7:0] sa;
    begin
      is_wide = (sa == `VPI_SUB_BLACK_LINE) || (sa == `VPI_SUB_PIN_DRIVER) ||
                (sa >= `VPI_SUB_CP_RD_ADDR && sa <= `VPI_SUB_CP_DATA);
    end
  endfunction

  wire [15:0] rword = rd_mux(sub_q);
  wire        data_wr = (st_q == S_ACK) && !rw_q && !is_addr_q && !is_sub_q;
  wire        last_b  = !is_wide(sub_q) || byte_n_q;

  always @(posedge sys_clk) begin
    if (!nrst || !ready) begin
      st_q      <= S_IDLE;
      sh_q      <= 8'h00;
      sub_q     <= 8'h00;
      bit_q     <= 4'h0;
      rw_q      <= 1'b0;
      byte_n_q  <= 1'b0;
      is_addr_q <= 1'b0;
      is_sub_q  <= 1'b0;
      mack_q    <= 1'b0;
      hi_q      <= 8'h00;
      sda_oe    <= 1'b0;
      scl_oe    <= 1'b0;
    end else if (start_c) begin
      // A repeated start keeps the subaddress for the read that follows
      st_q     <= S_ADDR;
      bit_q    <= 4'h0;
      sda_oe   <= 1'b0;
      byte_n_q <= 1'b0;
    end else if (stop_c) begin
      st_q   <= S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= 1'b0;
      case (st_q)
        S_IDLE: sda_oe <= 1'b0;
        S_ADDR, S_SUB, S_WDAT: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q     <= 4'h0;
            is_addr_q <= (st_q == S_ADDR);
            is_sub_q  <= (st_q == S_SUB);
            if (st_q == S_ADDR) begin
              rw_q <= sh_q[0];
              if (sh_q[7:1] == `VPI_ADDR_FRONT) begin
                sda_oe <= 1'b1;
                st_q   <= S_ACK;
              end else st_q <= S_IDLE;
            end else begin
              sda_oe <= 1'b1;
              st_q   <= S_ACK;
              if (st_q == S_SUB) begin
                sub_q    <= sh_q;
                byte_n_q <= 1'b0;
              end
            end
          end
        end
        S_ACK: if (scl_fall) begin
          sda_oe <= 1'b0;
          bit_q  <= 4'h0;
          if (is_addr_q && rw_q) begin
            st_q  <= S_RDAT;
            sh_q  <= is_wide(sub_q) ? rword[15:8] : rword[7:0];
            sda_oe <= ~(is_wide(sub_q) ? rword[15] : rword[7]);
            hi_q  <= rword[7:0];
          end else if (is_addr_q) st_q <= S_SUB;
          else begin
            if (data_wr) begin
              hi_q     <= sh_q;
              byte_n_q <= ~last_b;
            end
            st_q <= (data_wr && last_b && sub_q == `VPI_SUB_CP_DATA) ? S_IDLE : S_WDAT;
          end
          is_addr_q <= 1'b0;
          is_sub_q  <= 1'b0;
        end
        S_RDAT: begin
          if (scl_rise && bit_q == 4'h8) mack_q <= ~sda_q;
          else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oe <= 1'b0;
              bit_q  <= 4'h0;
              if (!mack_q || sub_q == `VPI_SUB_CP_DATA && byte_n_q) st_q <= S_IDLE;
              else begin
                byte_n_q <= 1'b1;
                sh_q     <= hi_q;
                sda_oe   <= ~hi_q[7];
              end
            end else if (bit_q == 4'h7) begin
              // Release the line so the master can acknowledge
              bit_q  <= 4'h8;
              sda_oe <= 1'b0;
            end else begin
              sh_q   <= {sh_q[6:0], 1'b0};
              sda_oe <= ~sh_q[6];
              bit_q  <= bit_q + 4'h1;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ========================================================
  // Register writes, sync latching and coprocessor mailbox
  wire        wr_done = data_wr && scl_fall && last_b;
  wire [15:0] wval    = is_wide(sub_q) ? {hi_q, sh_q} : {8'h00, sh_q};
  wire        rd_data = (st_q == S_RDAT) && scl_fall && bit_q == 4'h8 && byte_n_q &&
                        sub_q == `VPI_SUB_CP_DATA;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      pin_ctl_q     <= `VPI_RST_ZERO;
      pin_act_q     <= `VPI_RST_ZERO;
      sync_ctl_q    <= 8'h00;
      prio_ovr_q    <= 8'h00;
      prio_ctl_q    <= 8'h00;
      ovr_sh_q      <= 8'h00;
      pid_sh_q      <= 8'h00;
      rd_addr_q     <= 9'h000;
      wr_addr_q     <= 9'h000;
      wreq_q        <= 1'b0;
      rreq_q        <= 1'b0;
      black_q       <= `VPI_RST_ZERO;
      black_restart <= 1'b0;
      cp_wr_req     <= 1'b0;
      cp_rd_req     <= 1'b0;
      cp_wr_addr    <= 9'h000;
      cp_rd_addr    <= 9'h000;
      cp_wr_data    <= 12'h000;
    end else begin
      black_restart <= 1'b0;
      if (black_meas_done) begin
        black_q <= {black_picture_flag, upper_black_count, 1'b0, lower_black_count};
        black_restart <= 1'b1;
      end
      // Acknowledge first, so that a request arriving in the same cycle wins
      if (cp_ack) begin
        if (cp_wr_req) begin
          cp_wr_req <= 1'b0;
          wreq_q    <= 1'b0;
        end else if (cp_rd_req) begin
          cp_rd_req <= 1'b0;
          rreq_q    <= 1'b0;
        end
      end
      // Reads wait behind a pending write and are never raised again in the ack cycle
      if (rreq_q && !cp_wr_req && !cp_rd_req && !cp_ack) cp_rd_req <= 1'b1;
      if (wr_done) begin
        case (sub_q)
          `VPI_SUB_PIN_DRIVER: pin_ctl_q <= {10'h000, wval[5:4], 1'b0, wval[2:0]};
          `VPI_SUB_SYNC_GEN:   sync_ctl_q <= {wval[7], 7'h00};
          `VPI_SUB_PRIO_OVR:   ovr_sh_q <= wval[7:0];
          `VPI_SUB_PRIO_ID:    pid_sh_q <= {wval[7:6], 1'b0, wval[4:0]};
          `VPI_SUB_CP_RD_ADDR: begin
            rd_addr_q <= wval[8:0];
            rreq_q    <= 1'b1;
          end
          `VPI_SUB_CP_WR_ADDR: wr_addr_q <= wval[8:0];
          `VPI_SUB_CP_DATA: begin
            cp_wr_req  <= 1'b1;
            cp_wr_addr <= wr_addr_q;
            cp_wr_data <= wval[11:0];
            wreq_q     <= 1'b1;
            wr_addr_q  <= wr_addr_q + 9'h001;
          end
          default: ;
        endcase
      end
      if (rd_data) begin
        rd_addr_q <= rd_addr_q + 9'h001;
        rreq_q    <= 1'b1;
      end
      cp_rd_addr <= rd_addr_q;
      if (vs_edge) prio_ovr_q <= ovr_sh_q;
      if (hs_edge) begin
        prio_ctl_q <= pid_sh_q;
        pin_act_q  <= pin_ctl_q;
      end
    end
  end

  // ========================================================
  // Pin and priority outputs
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sync_int_q              <= 1'b0;
      interlace_signal        <= 1'b0;
      interlace_oe            <= 1'b0;
      output_strength         <= 3'h0;
      priority_overwrite_mask <= 8'h00;
      priority_level_id       <= 3'h0;
      priority_pad_strength   <= 2'h0;
      priority_request_source <= 1'b0;
      // Data pins stay released until the enable bit is written and latched at hsync
      priority_data_oe        <= 1'b0;
      init_busy               <= 1'b1;
    end else begin
      if (hs_edge) sync_int_q <= interlace_raw;
      interlace_signal <= (pin_act_q[5] ? interlace_raw : sync_int_q) ^ sync_ctl_q[7];
      interlace_oe     <= ~pin_act_q[4] && pin_act_q[2:0] != `VPI_STR_HIZ;
      output_strength  <= pin_act_q[2:0];
      priority_overwrite_mask <= prio_ovr_q;
      priority_level_id       <= prio_ctl_q[2:0];
      priority_pad_strength   <= prio_ctl_q[4:3];
      priority_request_source <= prio_ctl_q[6];
      priority_data_oe        <= prio_ctl_q[7];
      init_busy <= ~ready;
    end
  end
endmodule // vpi_port

/* testbench/vpi_port_asserts.sv */
// ==========================================
// Port checker
module vpi_port_asserts #(
  parameter INT_RESET_CYC = 8,
  parameter INIT_CYC      = 8
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       scl_oe,
  input wire logic       sda_oe,
  input wire logic       vsync,
  input wire logic       black_meas_done,
  input wire logic       black_restart,
  input wire logic       cp_wr_req,
  input wire logic       cp_ack,
  input wire logic [2:0] output_strength,
  input wire logic       interlace_oe,
  input wire logic [7:0] priority_overwrite_mask,
  input wire logic       init_busy
);
  logic [15:0] cnt_q;
  logic        vs_q;
  logic [3:0]  vcnt_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Saturating counters keep long spans out of the properties
  always @(posedge sys_clk) begin
    vs_q   <= vsync;
    cnt_q  <= !nrst ? 16'h0000 : (cnt_q == 16'hFFFF ? cnt_q : cnt_q + 16'h0001);
    vcnt_q <= !nrst ? 4'hF : (vsync && !vs_q) ? 4'h0 : (vcnt_q == 4'hF ? 4'hF : vcnt_q + 4'h1);
  end
  init_hold_a: assert property (cnt_q < INT_RESET_CYC |-> init_busy)
    else $error("init_busy low during internal reset");
  init_end_a: assert property (cnt_q > INT_RESET_CYC + INIT_CYC + 4 |-> !init_busy)
    else $error("init_busy still high after init");
  init_quiet_a: assert property (init_busy |-> !sda_oe)
    else $error("bus answered during init");
  no_stretch_a: assert property (!scl_oe)
    else $error("clock held low unexpectedly");
  sda_setup_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  pin_hiz_a: assert property (output_strength == 3'h7 && $stable(output_strength)
    |-> !interlace_oe)
    else $error("interlace pin driven at strength 7");
  black_restart_a: assert property (black_meas_done |=> black_restart)
    else $error("no restart after measurement");
  vlatch_mask_a: assert property ($changed(priority_overwrite_mask) |-> vcnt_q <= 4'h8)
    else $error("mask changed away from vsync");
  wreq_hold_a: assert property (cp_wr_req && !cp_ack |=> cp_wr_req)
    else $error("write request dropped before ack");
  cover property ($fell(init_busy));
  cover property ($rose(sda_oe));
  cover property ($rose(cp_wr_req));
  cover property ($changed(priority_overwrite_mask));
endmodule // vpi_port_asserts
bind vpi_port vpi_port_asserts #(.INT_RESET_CYC(INT_RESET_CYC), .INIT_CYC(INIT_CYC)) u_chk (
  .sys_clk, .nrst, .scl_in, .scl_oe, .sda_oe, .vsync, .black_meas_done, .black_restart,
  .cp_wr_req, .cp_ack, .output_strength, .interlace_oe, .priority_overwrite_mask, .init_busy);

/* testbench/vpi_i2c_master.sv */
// ==========================================
// Bus master model
module vpi_i2c_master #(
  parameter logic [6:0] ADDR = 7'h47
) (
  input  wire logic sys_clk,
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One quarter of the 160 ns bus period
  task automatic q(input logic s, input logic d);
    repeat (10) @(posedge sys_clk);
    scl_o <= s;
    sda_o <= d;
  endtask
  // Data only moves while the clock is low; start and stop move it high
  task automatic ph(input logic a, input logic b, input logic c);
    q(1'b0, sda_o);
    q(1'b0, a);
    q(1'b1, b);
    while (!scl_w) @(posedge sys_clk);
    q(1'b1, c);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
                      inout logic nak);
    for (int i = 7; i >= 0; i--) begin
      ph(d[i], d[i], d[i]);
      r[i] = sda_w;
    end
    ph(mack, mack, mack);
    nak = nak | sda_w;
  endtask
  task automatic probe(input logic [6:0] a, output logic nak);
    logic [7:0] r;
    nak = 1'b0;
    ph(1'b1, 1'b1, 1'b0);
    xfer({a, 1'b0}, 1'b1, r, nak);
    ph(1'b0, 1'b0, 1'b1);
  endtask
  task automatic wr(input logic [7:0] sa, input logic [15:0] v, input int n, output logic nak);
    logic [7:0] r;
    nak = 1'b0;
    ph(1'b1, 1'b1, 1'b0);
    xfer({ADDR, 1'b0}, 1'b1, r, nak);
    xfer(sa, 1'b1, r, nak);
    if (n == 2) xfer(v[15:8], 1'b1, r, nak);
    xfer(v[7:0], 1'b1, r, nak);
    ph(1'b0, 1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] sa, input int n, output logic [15:0] v, output logic nak);
    logic [7:0] r;
    logic       dm;
    nak = 1'b0;
    v = 16'h0000;
    ph(1'b1, 1'b1, 1'b0);
    xfer({ADDR, 1'b0}, 1'b1, r, nak);
    xfer(sa, 1'b1, r, nak);
    ph(1'b1, 1'b1, 1'b0);
    xfer({ADDR, 1'b1}, 1'b1, r, nak);
    if (n == 2) begin
      xfer(8'hFF, 1'b0, r, dm);
      v[15:8] = r;
    end
    xfer(8'hFF, 1'b1, r, dm);
    v[7:0] = r;
    ph(1'b0, 1'b0, 1'b1);
  endtask
endmodule // vpi_i2c_master

/* testbench/vpi_port_tb.sv */
`include "vpi_regs.vh"
// ==========================================
// Testbench
module vpi_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, vsync = 1'b0, hsync = 1'b0, black_meas_done = 1'b0;
  logic black_picture_flag = 1'b0, cp_ack = 1'b0, interlace_raw = 1'b0, ack_en = 1'b0, nak;
  logic [6:0] lower_black_count = 7'h00, upper_black_count = 7'h00;
  logic [11:0] cp_rd_data = 12'h5A5;
  logic [15:0] v;
  wire scl_m, sda_m, scl_oe, sda_oe, black_restart, cp_wr_req, cp_rd_req, interlace_signal;
  wire interlace_oe, priority_request_source, priority_data_oe, init_busy;
  wire [8:0] cp_wr_addr, cp_rd_addr;
  wire [11:0] cp_wr_data;
  wire [2:0] output_strength, priority_level_id;
  wire [1:0] priority_pad_strength;
  wire [7:0] priority_overwrite_mask;
  wire scl_in = scl_m & ~scl_oe;
  wire sda_in = sda_m & ~sda_oe;
  int n_fail = 0;
  int comparisons = 0;
  vpi_port #(.INT_RESET_CYC(200), .INIT_CYC(64)) DUT (.sys_clk, .nrst, .scl_in, .scl_oe,
    .sda_in, .sda_oe, .vsync, .hsync, .black_meas_done, .lower_black_count, .upper_black_count,
    .black_picture_flag, .black_restart, .cp_wr_req, .cp_wr_addr, .cp_wr_data, .cp_rd_req,
    .cp_rd_addr, .cp_rd_data, .cp_ack, .interlace_raw, .interlace_signal, .interlace_oe,
    .output_strength, .priority_overwrite_mask, .priority_level_id, .priority_pad_strength,
    .priority_request_source, .priority_data_oe, .init_busy);
  vpi_i2c_master #(.ADDR(`VPI_ADDR_FRONT)) m (.sys_clk, .scl_w(scl_in), .sda_w(sda_in),
    .scl_o(scl_m), .sda_o(sda_m));
  always #2 sys_clk = ~sys_clk;
  // Coprocessor side answers one cycle after a request, unless held off
  always @(posedge sys_clk) cp_ack <= ack_en & (cp_wr_req | cp_rd_req) & ~cp_ack;
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] sa, input int n, input logic [15:0] exp);
    m.rd(sa, n, v, nak);
    chk("read ack", 16'h0000, {15'h0000, nak});
    chk("read data", exp, v);
  endtask
  task automatic wr(input logic [7:0] sa, input logic [15:0] d, input int n);
    m.wr(sa, d, n, nak);
    chk("write ack", 16'h0000, {15'h0000, nak});
  endtask
  task automatic sync_pulse(input logic vs);
    @(posedge sys_clk);
    if (vs) vsync <= 1'b1;
    else hsync <= 1'b1;
    @(posedge sys_clk);
    vsync <= 1'b0;
    hsync <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic t_init;
    m.probe(`VPI_ADDR_FRONT, nak);
    chk("init ack", 16'h0001, {15'h0000, nak});
    for (int i = 0; i < 1000 && init_busy !== 1'b0; i++) @(posedge sys_clk);
    chk("init busy", 16'h0000, {15'h0000, init_busy});
    m.probe(`VPI_ADDR_BACK, nak);
    chk("foreign ack", 16'h0001, {15'h0000, nak});
    rchk(`VPI_SUB_PIN_DRIVER, 2, 16'h0000);
    rchk(`VPI_SUB_SYNC_GEN, 1, 16'h0000);
    rchk(`VPI_SUB_PRIO_OVR, 1, 16'h0000);
    rchk(`VPI_SUB_PRIO_ID, 1, 16'h0000);
    $display("init done");
  endtask
  task automatic t_prio;
    wr(`VPI_SUB_PRIO_OVR, 16'h00A5, 1);
    chk("mask early", 16'h0000, {8'h00, priority_overwrite_mask});
    sync_pulse(1'b1);
    chk("mask", 16'h00A5, {8'h00, priority_overwrite_mask});
    rchk(`VPI_SUB_PRIO_OVR, 1, 16'h00A5);
    wr(`VPI_SUB_PRIO_ID, 16'h00DD, 1);
    sync_pulse(1'b0);
    chk("prio ctl", 16'h007D, {9'h000, priority_data_oe, priority_request_source,
        priority_pad_strength, priority_level_id});
    wr(`VPI_SUB_PRIO_ID, 16'h0000, 1);
    sync_pulse(1'b0);
    chk("prio oe", 16'h0000, {15'h0000, priority_data_oe});
    $display("priority done");
  endtask
  task automatic t_pins;
    wr(`VPI_SUB_PIN_DRIVER, 16'h0027, 2);
    sync_pulse(1'b0);
    chk("pin hiz", 16'h0007, {12'h000, interlace_oe, output_strength});
    wr(`VPI_SUB_PIN_DRIVER, 16'h0020, 2);
    sync_pulse(1'b0);
    chk("pin on", 16'h0008, {12'h000, interlace_oe, output_strength});
    rchk(`VPI_SUB_PIN_DRIVER, 2, 16'h0020);
    wr(`VPI_SUB_SYNC_GEN, 16'h0080, 1);
    sync_pulse(1'b0);
    chk("polarity", 16'h0001, {15'h0000, interlace_signal});
    @(posedge sys_clk) interlace_raw <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk("unsynced", 16'h0000, {15'h0000, interlace_signal});
    $display("pins done");
  endtask
  task automatic t_black;
    @(posedge sys_clk);
    lower_black_count <= 7'h12;
    upper_black_count <= 7'h34;
    black_picture_flag <= 1'b1;
    black_meas_done <= 1'b1;
    @(posedge sys_clk);
    black_meas_done <= 1'b0;
    // Result register is only ever read, never written
    rchk(`VPI_SUB_BLACK_LINE, 2, 16'hB412);
    $display("black line done");
  endtask
  task automatic t_coproc;
    wr(`VPI_SUB_CP_WR_ADDR, 16'h0105, 2);
    wr(`VPI_SUB_CP_DATA, 16'h0ABC, 2);
    chk("wr addr", 16'h0105, {7'h00, cp_wr_addr});
    chk("wr data", 16'h0ABC, {4'h0, cp_wr_data});
    rchk(`VPI_SUB_CP_STATUS, 1, 16'h0005);
    @(posedge sys_clk) ack_en <= 1'b1;
    rchk(`VPI_SUB_CP_STATUS, 1, 16'h0000);
    @(posedge sys_clk) ack_en <= 1'b0;
    wr(`VPI_SUB_CP_DATA, 16'h0123, 2);
    chk("wr addr next", 16'h0106, {7'h00, cp_wr_addr});
    @(posedge sys_clk) ack_en <= 1'b1;
    wr(`VPI_SUB_CP_RD_ADDR, 16'h0010, 2);
    rchk(`VPI_SUB_CP_DATA, 2, 16'h05A5);
    chk("rd addr next", 16'h0011, {7'h00, cp_rd_addr});
    chk("rd req idle", 16'h0000, {15'h0000, cp_rd_req});
    $display("coprocessor done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_init;
    t_prio;
    t_pins;
    t_black;
    t_coproc;
    finish_test;
  end
  // Passing run needs roughly 130 us of bus traffic
  initial begin
    #400000;
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    finish_test;
  end
endmodule // vpi_port_tb
